// file: icsp_pkg.sv
package icsp_pkg;

    // ========================================================
    // Addressing
    localparam logic [3:0] DEV_ADDR_PREFIX = 4'h6;
    localparam logic       DIR_WRITE       = 1'b0;
    localparam logic       DIR_READ        = 1'b1;
    localparam logic [7:0] RX_FILL_BYTE    = 8'hff;

    // ========================================================
    // Register store
    localparam int         CFG_REG_COUNT = 16;
    localparam logic [7:0] CFG_RST_VAL   = 8'h00;
    localparam logic [7:0] IDX_RST_VAL   = 8'h00;

    // ========================================================
    // Timing
    localparam int CLK_HZ        = 25000000;
    localparam int BIT_RATE_KBPS = 400;
    // Quarter bit, rounded up so the bit rate never exceeds the limit
    localparam int QTR_CYCLES    = (CLK_HZ + 4 * BIT_RATE_KBPS * 1000 - 1)
                                   / (4 * BIT_RATE_KBPS * 1000);

    // ========================================================
    // Synchroniser reset: lines released, chip reset asserted
    localparam logic [5:0] SYNC_RST_VAL = 6'h03;

    // ========================================================
    // States
    typedef enum logic [3:0] {
        DS_IDLE, DS_ADDR, DS_ADDR_ACK, DS_IDX, DS_IDX_ACK,
        DS_WDATA, DS_WDATA_ACK, DS_RDATA, DS_RDATA_ACK
    } icsp_dev_state_e;

    typedef enum logic [1:0] {
        HS_IDLE, HS_START, HS_BIT, HS_STOP
    } icsp_host_state_e;

endpackage

// file: icsp_if.sv
`timescale 1ns/1ns
interface icsp_if;
    logic scl_oe_m;
    logic sda_oe_m;
    logic sda_oe_s;
    logic scl;
    logic sda;

    // ========================================================
    // Open-drain wired AND with pull-ups
    assign scl = ~scl_oe_m;
    assign sda = ~(sda_oe_m | sda_oe_s);

    modport master (output scl_oe_m, output sda_oe_m, input scl, input sda);
    modport slave  (output sda_oe_s, input scl, input sda);
endinterface

// file: icsp_host.sv
`timescale 1ns/1ns
module icsp_host #(
    parameter int QTR = icsp_pkg::QTR_CYCLES
) (
    icsp_if.master            bus,
    input  wire logic         clk,
    input  wire logic         sys_rst,
    input  wire logic         cmd_valid,
    input  wire logic         cmd_read,
    input  wire logic [6:0]   cmd_addr,
    input  wire logic [7:0]   cmd_index,
    input  wire logic [7:0]   cmd_wdata,
    output logic              busy,
    output logic              done,
    output logic              nack_err,
    output logic [7:0]        rdata
);
    import icsp_pkg::*;

    // ========================================================
    // Byte to send for a given slot of the sequence
    function automatic logic [7:0] byte_sel(input logic [1:0] b, input logic sec,
                                            input logic [6:0] a, input logic [7:0] ix,
                                            input logic [7:0] wd);
        if (sec)
            byte_sel = (b == 2'd0) ? {a, DIR_READ} : RX_FILL_BYTE;
        else if (b == 2'd0)
            byte_sel = {a, DIR_WRITE};
        else if (b == 2'd1)
            byte_sel = ix;
        else
            byte_sel = wd;
    endfunction

    icsp_host_state_e state_reg, state_next;
    logic [1:0]  sda_s1_reg, sda_s2_reg, sda_next;
    logic [7:0]  qcnt_reg, qcnt_next;
    logic [1:0]  ph_reg, ph_next;
    logic [3:0]  bitn_reg, bitn_next;
    logic [1:0]  byte_reg, byte_next;
    logic        sec_reg, sec_next;
    logic        rd_reg, rd_next;
    logic        restart_reg, restart_next;
    logic [6:0]  addr_reg, addr_next;
    logic [7:0]  idx_reg, idx_next;
    logic [7:0]  wd_reg, wd_next;
    logic [8:0]  tx_reg, tx_next;
    logic [8:0]  rx_reg, rx_next;
    logic        scl_oe_reg, scl_oe_next;
    logic        sda_oe_reg, sda_oe_next;
    logic        busy_reg, busy_next;
    logic        done_reg, done_next;
    logic        err_reg, err_next;
    logic [7:0]  rdata_reg, rdata_next;
    logic        tick;
    logic [8:0]  rx_new;
    logic        is_tx;

    assign sda_next = {sda_s1_reg[0], bus.sda};
    assign tick     = (qcnt_reg == 8'(QTR - 1));
    assign rx_new   = {rx_reg[7:0], sda_s2_reg[0]};
    assign is_tx    = !(rd_reg && sec_reg && byte_reg == 2'd1);

    // ========================================================
    // Sequencer
    always_comb begin
        state_next   = state_reg;
        qcnt_next    = tick ? 8'h00 : qcnt_reg + 8'h01;
        ph_next      = tick ? ph_reg + 2'd1 : ph_reg;
        bitn_next    = bitn_reg;
        byte_next    = byte_reg;
        sec_next     = sec_reg;
        rd_next      = rd_reg;
        restart_next = restart_reg;
        addr_next    = addr_reg;
        idx_next     = idx_reg;
        wd_next      = wd_reg;
        tx_next      = tx_reg;
        rx_next      = rx_reg;
        scl_oe_next  = scl_oe_reg;
        sda_oe_next  = sda_oe_reg;
        busy_next    = busy_reg;
        done_next    = 1'b0;
        err_next     = err_reg;
        rdata_next   = rdata_reg;
        case (state_reg)
            HS_IDLE: begin
                qcnt_next = 8'h00;
                ph_next   = 2'd0;
                if (cmd_valid) begin
                    state_next = HS_START;
                    rd_next    = cmd_read;
                    addr_next  = cmd_addr;
                    idx_next   = cmd_index;
                    wd_next    = cmd_wdata;
                    byte_next  = 2'd0;
                    sec_next   = 1'b0;
                    busy_next  = 1'b1;
                    err_next   = 1'b0;
                end
            end
            HS_START: if (tick) begin
                if (ph_reg == 2'd1)
                    sda_oe_next = 1'b1;
                else if (ph_reg == 2'd2)
                    scl_oe_next = 1'b1;
                else if (ph_reg == 2'd3) begin
                    state_next = HS_BIT;
                    bitn_next  = 4'd0;
                    tx_next    = {byte_sel(byte_reg, sec_reg, addr_reg, idx_reg, wd_reg), 1'b1};
                end
            end
            HS_BIT: if (tick) begin
                if (ph_reg == 2'd0)
                    sda_oe_next = ~tx_reg[8];
                else if (ph_reg == 2'd1)
                    scl_oe_next = 1'b0;
                else if (ph_reg == 2'd3) begin
                    scl_oe_next = 1'b1;
                    rx_next     = rx_new;
                    tx_next     = {tx_reg[7:0], 1'b1};
                    bitn_next   = bitn_reg + 4'd1;
                    if (bitn_reg == 4'd8) begin
                        bitn_next    = 4'd0;
                        restart_next = 1'b0;
                        state_next   = HS_STOP;
                        if (is_tx && rx_new[0]) begin
                            err_next = 1'b1;
                        end else if (!rd_reg) begin
                            if (byte_reg != 2'd2) begin
                                state_next = HS_BIT;
                                byte_next  = byte_reg + 2'd1;
                                tx_next    = {byte_sel(byte_reg + 2'd1, sec_reg, addr_reg,
                                                       idx_reg, wd_reg), 1'b1};
                            end
                        end else if (!sec_reg) begin
                            if (byte_reg == 2'd1)
                                restart_next = 1'b1;
                            else begin
                                state_next = HS_BIT;
                                byte_next  = 2'd1;
                                tx_next    = {idx_reg, 1'b1};
                            end
                        end else if (byte_reg == 2'd0) begin
                            state_next = HS_BIT;
                            byte_next  = 2'd1;
                            tx_next    = {RX_FILL_BYTE, 1'b1};
                        end else begin
                            rdata_next = rx_new[8:1];
                        end
                    end
                end
            end
            HS_STOP: if (tick) begin
                if (ph_reg == 2'd0)
                    sda_oe_next = 1'b1;
                else if (ph_reg == 2'd1)
                    scl_oe_next = 1'b0;
                else if (ph_reg == 2'd2)
                    sda_oe_next = 1'b0;
                else if (restart_reg) begin
                    state_next = HS_START;
                    byte_next  = 2'd0;
                    sec_next   = 1'b1;
                end else begin
                    state_next = HS_IDLE;
                    busy_next  = 1'b0;
                    done_next  = 1'b1;
                end
            end
            default: state_next = HS_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg   <= HS_IDLE;
            sda_s1_reg  <= 2'b11;
            sda_s2_reg  <= 2'b11;
            qcnt_reg    <= 8'h00;
            ph_reg      <= 2'd0;
            bitn_reg    <= 4'd0;
            byte_reg    <= 2'd0;
            sec_reg     <= 1'b0;
            rd_reg      <= 1'b0;
            restart_reg <= 1'b0;
            addr_reg    <= 7'h00;
            idx_reg     <= 8'h00;
            wd_reg      <= 8'h00;
            tx_reg      <= 9'h1ff;
            rx_reg      <= 9'h000;
            scl_oe_reg  <= 1'b0;
            sda_oe_reg  <= 1'b0;
            busy_reg    <= 1'b0;
            done_reg    <= 1'b0;
            err_reg     <= 1'b0;
            rdata_reg   <= 8'h00;
        end else begin
            state_reg   <= state_next;
            sda_s1_reg  <= sda_next;
            sda_s2_reg  <= sda_s1_reg;
            qcnt_reg    <= qcnt_next;
            ph_reg      <= ph_next;
            bitn_reg    <= bitn_next;
            byte_reg    <= byte_next;
            sec_reg     <= sec_next;
            rd_reg      <= rd_next;
            restart_reg <= restart_next;
            addr_reg    <= addr_next;
            idx_reg     <= idx_next;
            wd_reg      <= wd_next;
            tx_reg      <= tx_next;
            rx_reg      <= rx_next;
            scl_oe_reg  <= scl_oe_next;
            sda_oe_reg  <= sda_oe_next;
            busy_reg    <= busy_next;
            done_reg    <= done_next;
            err_reg     <= err_next;
            rdata_reg   <= rdata_next;
        end
    end

    assign bus.scl_oe_m = scl_oe_reg;
    assign bus.sda_oe_m = sda_oe_reg;
    assign busy         = busy_reg;
    assign done         = done_reg;
    assign nack_err     = err_reg;
    assign rdata        = rdata_reg;
endmodule

// file: icsp_device.sv
`timescale 1ns/1ns
// Functional notes
// - Bytes MSB first, sampled while clock high
// - Receiver acknowledges each byte by pulling data, except the master on the final read byte
// - Works at bit rates up to 400 kbps
// - Start is data falling while clock high
// - First byte: seven-bit address plus direction
// - Match 0110 plus three strap levels
// - After address ack, bytes flow chosen direction
// - Stop is data rising while clock high
// - Write: address, index, data, each acknowledged
// - Read: set index by write, restart reading
// - Device sends byte; master NACKs then stops
// - Every config register writable and readable
module icsp_device #(
    parameter int REG_COUNT = icsp_pkg::CFG_REG_COUNT
) (
    icsp_if.slave                       bus,
    input  wire logic                   clk,
    input  wire logic                   sys_rst,
    input  wire logic                   chip_reset_n,
    input  wire logic                   address_strap_bit2,
    input  wire logic                   address_strap_bit1,
    input  wire logic                   address_strap_bit0,
    output logic [REG_COUNT-1:0][7:0]   cfg_values,
    output logic                        wr_strobe,
    output logic [7:0]                  wr_index,
    output logic [7:0]                  wr_data
);
    import icsp_pkg::*;

    // ========================================================
    // Register read with out-of-range indices reading as zero
    function automatic logic [7:0] rd_byte(input logic [REG_COUNT-1:0][7:0] regs,
                                           input logic [7:0] ix);
        rd_byte = 8'h00;
        for (int i = 0; i < REG_COUNT; i++) begin
            if (ix == 8'(i))
                rd_byte = regs[i];
        end
    endfunction

    // ========================================================
    // Input synchronisers: {chip_reset_n, strap2..0, scl, sda}
    logic [5:0] sync1_reg, sync2_reg, sync_in;
    logic       scl_d_reg, sda_d_reg;
    logic       rstn_s, scl_s, sda_s;
    logic [2:0] strap_s;
    logic       scl_rise, scl_fall, start_det, stop_det;

    assign sync_in  = {chip_reset_n, address_strap_bit2, address_strap_bit1,
                       address_strap_bit0, bus.scl, bus.sda};
    assign rstn_s   = sync2_reg[5];
    assign strap_s  = sync2_reg[4:2];
    assign scl_s    = sync2_reg[1];
    assign sda_s    = sync2_reg[0];
    assign scl_rise = scl_s & ~scl_d_reg;
    assign scl_fall = ~scl_s & scl_d_reg;
    assign start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
    assign stop_det  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sync1_reg <= SYNC_RST_VAL;
            sync2_reg <= SYNC_RST_VAL;
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
        end else begin
            sync1_reg <= sync_in;
            sync2_reg <= sync1_reg;
            scl_d_reg <= scl_s;
            sda_d_reg <= sda_s;
        end
    end

    // ========================================================
    // Port state machine
    icsp_dev_state_e          state_reg, state_next;
    logic [3:0]               cnt_reg, cnt_next;
    logic [7:0]               shift_reg, shift_next;
    logic [7:0]               tx_reg, tx_next;
    logic [7:0]               idx_reg, idx_next;
    logic                     rw_reg, rw_next;
    logic                     ack_reg, ack_next;
    logic                     oe_reg, oe_next;
    logic                     wr_reg, wr_next;
    logic [7:0]               wr_index_reg, wr_index_next;
    logic [7:0]               wr_data_reg, wr_data_next;
    logic [REG_COUNT-1:0][7:0] cfg_reg, cfg_next;
    logic [7:0]               rd_now;
    logic [7:0]               rd_after;
    logic                     rx_state;

    assign rd_now   = rd_byte(cfg_reg, idx_reg);
    assign rd_after = rd_byte(cfg_reg, idx_reg + 8'h01);
    assign rx_state = (state_reg == DS_ADDR) || (state_reg == DS_IDX) ||
                      (state_reg == DS_WDATA);

    always_comb begin
        state_next    = state_reg;
        cnt_next      = cnt_reg;
        shift_next    = shift_reg;
        tx_next       = tx_reg;
        idx_next      = idx_reg;
        rw_next       = rw_reg;
        ack_next      = ack_reg;
        oe_next       = oe_reg;
        wr_next       = 1'b0;
        wr_index_next = wr_index_reg;
        wr_data_next  = wr_data_reg;
        cfg_next      = cfg_reg;
        if (!rstn_s) begin
            state_next = DS_IDLE;
            oe_next    = 1'b0;
            cnt_next   = 4'd0;
            idx_next   = IDX_RST_VAL;
            cfg_next   = {REG_COUNT{CFG_RST_VAL}};
        end else if (start_det) begin
            // Repeated start is honoured from any state
            state_next = DS_ADDR;
            cnt_next   = 4'd0;
            oe_next    = 1'b0;
        end else if (stop_det) begin
            state_next = DS_IDLE;
            oe_next    = 1'b0;
        end else begin
            if (rx_state && scl_rise && cnt_reg != 4'd8) begin
                shift_next = {shift_reg[6:0], sda_s};
                cnt_next   = cnt_reg + 4'd1;
            end
            case (state_reg)
                DS_IDLE: oe_next = 1'b0;
                DS_ADDR: if (scl_fall && cnt_reg == 4'd8) begin
                    if (shift_reg[7:1] == {DEV_ADDR_PREFIX, strap_s}) begin
                        oe_next    = 1'b1;
                        rw_next    = shift_reg[0];
                        state_next = DS_ADDR_ACK;
                    end else begin
                        state_next = DS_IDLE;
                    end
                end
                DS_ADDR_ACK: if (scl_fall) begin
                    cnt_next = 4'd0;
                    if (rw_reg == DIR_READ) begin
                        tx_next    = rd_now;
                        oe_next    = ~rd_now[7];
                        state_next = DS_RDATA;
                    end else begin
                        oe_next    = 1'b0;
                        state_next = DS_IDX;
                    end
                end
                DS_IDX: if (scl_fall && cnt_reg == 4'd8) begin
                    idx_next   = shift_reg;
                    oe_next    = 1'b1;
                    state_next = DS_IDX_ACK;
                end
                DS_IDX_ACK: if (scl_fall) begin
                    oe_next    = 1'b0;
                    cnt_next   = 4'd0;
                    state_next = DS_WDATA;
                end
                DS_WDATA: if (scl_fall && cnt_reg == 4'd8) begin
                    for (int i = 0; i < REG_COUNT; i++) begin
                        if (idx_reg == 8'(i))
                            cfg_next[i] = shift_reg;
                    end
                    wr_next       = 1'b1;
                    wr_index_next = idx_reg;
                    wr_data_next  = shift_reg;
                    oe_next       = 1'b1;
                    state_next    = DS_WDATA_ACK;
                end
                DS_WDATA_ACK: if (scl_fall) begin
                    // Further bytes land at following indices
                    oe_next    = 1'b0;
                    cnt_next   = 4'd0;
                    idx_next   = idx_reg + 8'h01;
                    state_next = DS_WDATA;
                end
                DS_RDATA: begin
                    if (scl_rise)
                        cnt_next = cnt_reg + 4'd1;
                    if (scl_fall) begin
                        if (cnt_reg == 4'd8) begin
                            oe_next    = 1'b0;
                            state_next = DS_RDATA_ACK;
                        end else begin
                            tx_next = {tx_reg[6:0], 1'b0};
                            oe_next = ~tx_reg[6];
                        end
                    end
                end
                DS_RDATA_ACK: begin
                    if (scl_rise)
                        ack_next = ~sda_s;
                    if (scl_fall) begin
                        cnt_next = 4'd0;
                        if (ack_reg) begin
                            // Master wants more: stream next index
                            idx_next   = idx_reg + 8'h01;
                            tx_next    = rd_after;
                            oe_next    = ~rd_after[7];
                            state_next = DS_RDATA;
                        end else begin
                            state_next = DS_IDLE;
                        end
                    end
                end
                default: state_next = DS_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg    <= DS_IDLE;
            cnt_reg      <= 4'd0;
            shift_reg    <= 8'h00;
            tx_reg       <= 8'h00;
            idx_reg      <= IDX_RST_VAL;
            rw_reg       <= DIR_WRITE;
            ack_reg      <= 1'b0;
            oe_reg       <= 1'b0;
            wr_reg       <= 1'b0;
            wr_index_reg <= 8'h00;
            wr_data_reg  <= 8'h00;
            cfg_reg      <= {REG_COUNT{CFG_RST_VAL}};
        end else begin
            state_reg    <= state_next;
            cnt_reg      <= cnt_next;
            shift_reg    <= shift_next;
            tx_reg       <= tx_next;
            idx_reg      <= idx_next;
            rw_reg       <= rw_next;
            ack_reg      <= ack_next;
            oe_reg       <= oe_next;
            wr_reg       <= wr_next;
            wr_index_reg <= wr_index_next;
            wr_data_reg  <= wr_data_next;
            cfg_reg      <= cfg_next;
        end
    end

    // Edge detection on the synchronised lines keeps 400 kbps far inside
    // the 25 MHz sampling budget
    assign bus.sda_oe_s = oe_reg;
    assign cfg_values   = cfg_reg;
    assign wr_strobe    = wr_reg;
    assign wr_index     = wr_index_reg;
    assign wr_data      = wr_data_reg;
endmodule

// file: icsp_sva.sv
`timescale 1ns/1ns
module icsp_sva (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic scl_oe_m,
    input wire logic sda_oe_m,
    input wire logic sda_oe_s,
    input wire logic scl,
    input wire logic sda
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // ========================================================
    // Cycles since the master last pulled the clock low, saturating
    logic       scl_q_reg;
    logic [7:0] per_cnt_reg;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            scl_q_reg   <= 1'b0;
            per_cnt_reg <= 8'hff;
        end else begin
            scl_q_reg <= scl_oe_m;
            if (scl_oe_m && !scl_q_reg)
                per_cnt_reg <= 8'h01;
            else if (per_cnt_reg != 8'hff)
                per_cnt_reg <= per_cnt_reg + 8'h01;
        end
    end
    // 63 cycles of 40 ns keep the bit period at or above 2.5 us
    property p_bit_rate;     $rose(scl_oe_m) |-> per_cnt_reg >= 8'h3f;      endproperty
    a_bit_rate:     assert property (p_bit_rate) else $error("clock period too short");
    // ========================================================
    // Bus conditions
    sequence s_start;
        scl && $past(scl) && $fell(sda);
    endsequence
    sequence s_stop;
        scl && $past(scl) && $rose(sda);
    endsequence
    property p_start_hold;   s_start |-> scl[*8];                         endproperty
    property p_start_quiet;  s_start |-> !sda_oe_s[*8];                   endproperty
    property p_stop_release; s_stop |-> !sda_oe_s[*8];                    endproperty
    property p_dev_stable;   scl && $past(scl) |-> $stable(sda_oe_s);     endproperty
    property p_ack_rise_low; $rose(sda_oe_s) |-> !scl[*8];                endproperty
    property p_dev_fall_low; $fell(sda_oe_s) |-> !scl[*8];                endproperty
    property p_scl_low_min;  $fell(scl) |-> !scl[*8];                     endproperty
    property p_scl_high_min; $rose(scl) |-> scl[*8];                      endproperty
    a_start_hold:   assert property (p_start_hold) else $error("start hold short");
    a_start_quiet:  assert property (p_start_quiet) else $error("device drives at start");
    a_stop_release: assert property (p_stop_release) else $error("device drives after stop");
    a_dev_stable:   assert property (p_dev_stable) else $error("device data moved, clock high");
    a_ack_rise_low: assert property (p_ack_rise_low) else $error("device drive not in low");
    a_dev_fall_low: assert property (p_dev_fall_low) else $error("device release not in low");
    a_scl_low_min:  assert property (p_scl_low_min) else $error("clock low too short");
    a_scl_high_min: assert property (p_scl_high_min) else $error("clock high too short");
endmodule

// file: i2c_config_slave_port_test.sv
`timescale 1ns/1ns
module i2c_config_slave_port_test;
    import icsp_pkg::*;
    logic              clk, sys_rst, cmd_valid, cmd_read, chip_reset_n;
    logic              busy, done, nack_err, wr_strobe;
    logic [2:0]        straps;
    logic [6:0]        cmd_addr;
    logic [7:0]        cmd_index, cmd_wdata, rdata, wr_index, wr_data, first_byte;
    logic [15:0][7:0]  cfg_values;
    int                num_errors, cmp_count, nbits, n_strobe;
    icsp_if bus ();
    icsp_host i_icsp_host (.bus(bus.master), .clk(clk), .sys_rst(sys_rst),
        .cmd_valid(cmd_valid), .cmd_read(cmd_read), .cmd_addr(cmd_addr),
        .cmd_index(cmd_index), .cmd_wdata(cmd_wdata), .busy(busy), .done(done),
        .nack_err(nack_err), .rdata(rdata));
    icsp_device i_icsp_device (.bus(bus.slave), .clk(clk), .sys_rst(sys_rst),
        .chip_reset_n(chip_reset_n), .address_strap_bit2(straps[2]),
        .address_strap_bit1(straps[1]), .address_strap_bit0(straps[0]),
        .cfg_values(cfg_values), .wr_strobe(wr_strobe), .wr_index(wr_index), .wr_data(wr_data));
    icsp_sva i_icsp_sva (.clk(clk), .sys_rst(sys_rst), .scl_oe_m(bus.scl_oe_m),
        .sda_oe_m(bus.sda_oe_m), .sda_oe_s(bus.sda_oe_s), .scl(bus.scl), .sda(bus.sda));
    // ========================================================
    // Wire monitor: first byte after the latest start, bit by bit
    always @(negedge bus.sda) if (bus.scl === 1'b1) nbits = 0;
    always @(posedge bus.scl) begin
        if (nbits < 8) first_byte = {first_byte[6:0], bus.sda};
        nbits++;
    end
    always @(posedge clk) if (wr_strobe === 1'b1) n_strobe++;
    task automatic check(input string nm, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic test_done();
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Waits for done; the bound is well above the longest read
    task automatic run_cmd(input logic rd, input logic [6:0] a, input logic [7:0] ix,
                           input logic [7:0] wd);
        int n;
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_read  <= rd;
        cmd_addr  <= a;
        cmd_index <= ix;
        cmd_wdata <= wd;
        @(posedge clk);
        cmd_valid <= 1'b0;
        @(negedge clk);
        check("busy", 8'h01, {7'h00, busy});
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (done !== 1'b1 && n < 8000);
        check("done", 8'h01, {7'h00, done});
        check("busy end", 8'h00, {7'h00, busy});
    endtask
    // ========================================================
    // Scenarios
    task automatic t_write_read(input logic [7:0] ix, input logic [7:0] d);
        logic [6:0] own;
        int         s0;
        own = {DEV_ADDR_PREFIX, straps};
        s0 = n_strobe;
        run_cmd(DIR_WRITE, own, ix, d);
        check("wr nack", 8'h00, {7'h00, nack_err});
        check("addr byte w", {own, DIR_WRITE}, first_byte);
        check("strobes", 8'h01, 8'(n_strobe - s0));
        check("wr_index", ix, wr_index);
        check("wr_data", d, wr_data);
        if (ix < 16) check("cfg", d, cfg_values[ix[3:0]]);
        run_cmd(DIR_READ, own, ix, 8'h00);
        check("addr byte r", {own, DIR_READ}, first_byte);
        check("rd nack", 8'h00, {7'h00, nack_err});
        check("rdata", (ix < 16) ? d : 8'h00, rdata);
    endtask
    task automatic t_mismatch(input logic [6:0] a);
        int s0;
        s0 = n_strobe;
        run_cmd(DIR_WRITE, a, 8'h00, 8'h77);
        check("miss nack", 8'h01, {7'h00, nack_err});
        check("miss strobes", 8'h00, 8'(n_strobe - s0));
        check("miss cfg", 8'ha5, cfg_values[0]);
    endtask
    task automatic t_chip_reset();
        @(posedge clk);
        chip_reset_n <= 1'b0;
        repeat (6) @(posedge clk);
        check("cfg0 rst", CFG_RST_VAL, cfg_values[0]);
        check("cfg15 rst", CFG_RST_VAL, cfg_values[15]);
        chip_reset_n <= 1'b1;
        repeat (6) @(posedge clk);
        t_write_read(8'h03, 8'h81);
    endtask
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        #4000000;
        num_errors++;
        test_done();
    end
    initial begin
        {sys_rst, chip_reset_n, cmd_valid, cmd_read} = 4'b1100;
        {cmd_addr, cmd_index, cmd_wdata, straps} = '0;
        {num_errors, cmp_count, nbits, n_strobe} = '0;
        straps = 3'b101;
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (6) @(posedge clk);
        t_write_read(8'h0f, 8'h3c);
        t_write_read(8'h00, 8'ha5);
        t_mismatch({DEV_ADDR_PREFIX, 3'b100});
        t_mismatch({4'h5, 3'b101});
        @(posedge clk);
        straps <= 3'b010;
        repeat (4) @(posedge clk);
        t_write_read(8'h10, 8'h5a);
        t_chip_reset();
        test_done();
    end
endmodule
